// ### hdl/alarm_frame_snapshot_map.vh
// Register map and constants for the alarm frame snapshot block
`ifndef ALARM_FRAME_SNAPSHOT_MAP_VH
`define ALARM_FRAME_SNAPSHOT_MAP_VH
// Frame geometry
`define FRAME_BYTES 7'h30
`define FRAME_WORDS 4'hC
`define FRAME_LAST_WORD 4'hB
// APB address regions (byte address bits 7:6) and word indices (bits 5:2)
`define ADDR_W 12
`define REGION_CMD 2'h0
`define REGION_RSP 2'h1
`define REGION_CTL 2'h2
`define CTRL_WORD 4'h0
`define STAT_WORD 4'h1
// Control register fields
`define CTRL_STOP_EN_BIT 0
`define CTRL_RESET 32'h0000_0001
// Status register fields
`define STAT_POWER_BIT 0
`define STAT_CONN_BIT 1
`define STAT_STOP_BIT 2
`define STAT_FWD_BIT 3
`define STAT_REV_BIT 4
`define STAT_VALID_BIT 5
`define STAT_CNT_LSB 8
`define STAT_CNT_MSB 15
// Host command codes
`define CMD_CONNECT 8'h0E
`define CMD_DISCONNECT 8'h0F
`define CMD_POWER_ON 8'h31
`define CMD_POWER_OFF 8'h32
// Link states
`define LINK_IDLE 1'b0
`define LINK_UP 1'b1
`endif

// ### hdl/alarm_frame_snapshot.v
// Alarm frame snapshot registers and start-inhibit logic with APB access
//
// Function
// - On alarm or warning, copy all 48 current command frame bytes to snapshot.
// - On the same event, copy all 48 response frame bytes to separate snapshot.
// - Lowest frame byte in bits 7:0, highest in 31:24; bytes 0-3 form word 0.
// - Each next group of four bytes fills the next word, up to bytes 44-47.
// - Warnings trigger capture too, including data-setting and command warnings.
// - Motor may not start while the forced-stop input is off.
// - Stop input allocation setting can disable forced stop; then it never blocks.
// - Drive in a direction only while that direction's limit input is on.
//
// Design decisions made here: the APB slave port and the address map.
`include "alarm_frame_snapshot_map.vh"
`default_nettype none
module alarm_frame_snapshot (
   input wire sys_clk_in,
   input wire rst_b_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [11:0] paddr_in,
   input wire [31:0] pwdata_in,
   output wire pready_out,
   output reg [31:0] prdata_out,
   output reg pslverr_out,
   input wire cmd_byte_we_in,
   input wire [5:0] cmd_byte_idx_in,
   input wire [7:0] cmd_byte_in,
   input wire rsp_byte_we_in,
   input wire [5:0] rsp_byte_idx_in,
   input wire [7:0] rsp_byte_in,
   input wire host_cmd_valid_in,
   input wire [7:0] host_cmd_code_in,
   input wire alarm_event_in,
   input wire data_warning_in,
   input wire command_warning_in,
   input wire forced_stop_input_in,
   input wire forward_limit_input_in,
   input wire reverse_limit_input_in,
   output reg motor_power_out,
   output reg fwd_drive_allow_out,
   output reg rev_drive_allow_out,
   output reg order_warning_out
);

   integer i;

   // Live frames and frozen copies
   reg [31:0] cmd_live_r [0:11];
   reg [31:0] rsp_live_r [0:11];
   reg [31:0] cmd_snap_r [0:11];
   reg [31:0] rsp_snap_r [0:11];

   reg [31:0] ctrl_r;
   reg snap_valid_r;
   reg [7:0] snap_cnt_r;
   reg link_state_r;
   reg power_r;

   // Pin synchronisers
   reg stop_s1_r;
   reg stop_s2_r;
   reg fwd_s1_r;
   reg fwd_s2_r;
   reg rev_s1_r;
   reg rev_s2_r;

   wire stop_block;
   wire any_event;
   wire cmd_in_range;
   wire rsp_in_range;
   wire order_fault;

   always @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         stop_s1_r <= 1'b0;
         stop_s2_r <= 1'b0;
         fwd_s1_r <= 1'b0;
         fwd_s2_r <= 1'b0;
         rev_s1_r <= 1'b0;
         rev_s2_r <= 1'b0;
      end else begin
         stop_s1_r <= forced_stop_input_in;
         stop_s2_r <= stop_s1_r;
         fwd_s1_r <= forward_limit_input_in;
         fwd_s2_r <= fwd_s1_r;
         rev_s1_r <= reverse_limit_input_in;
         rev_s2_r <= rev_s1_r;
      end
   end

   // Forced stop blocks only while enabled by allocation setting
   assign stop_block = ctrl_r[`CTRL_STOP_EN_BIT] & ~stop_s2_r;

   // Power-on before connect is out of order
   assign order_fault = host_cmd_valid_in && (host_cmd_code_in == `CMD_POWER_ON) &&
                        (link_state_r != `LINK_UP);

   // Alarms and all warnings trigger capture
   assign any_event = alarm_event_in | data_warning_in | command_warning_in | order_fault;

   assign cmd_in_range = {1'b0, cmd_byte_idx_in} < `FRAME_BYTES;
   assign rsp_in_range = {1'b0, rsp_byte_idx_in} < `FRAME_BYTES;

   // Live frame byte assembly, little-endian lanes
   always @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         for (i = 0; i < 12; i = i + 1) begin
            cmd_live_r[i] <= 32'h0000_0000;
            rsp_live_r[i] <= 32'h0000_0000;
         end
      end else begin
         if (cmd_byte_we_in && cmd_in_range) begin
            // Byte n lands in word n/4, lane n%4
            case (cmd_byte_idx_in[1:0])
               2'h0: cmd_live_r[cmd_byte_idx_in[5:2]][7:0] <= cmd_byte_in;
               2'h1: cmd_live_r[cmd_byte_idx_in[5:2]][15:8] <= cmd_byte_in;
               2'h2: cmd_live_r[cmd_byte_idx_in[5:2]][23:16] <= cmd_byte_in;
               default: cmd_live_r[cmd_byte_idx_in[5:2]][31:24] <= cmd_byte_in;
            endcase
         end
         if (rsp_byte_we_in && rsp_in_range) begin
            case (rsp_byte_idx_in[1:0])
               2'h0: rsp_live_r[rsp_byte_idx_in[5:2]][7:0] <= rsp_byte_in;
               2'h1: rsp_live_r[rsp_byte_idx_in[5:2]][15:8] <= rsp_byte_in;
               2'h2: rsp_live_r[rsp_byte_idx_in[5:2]][23:16] <= rsp_byte_in;
               default: rsp_live_r[rsp_byte_idx_in[5:2]][31:24] <= rsp_byte_in;
            endcase
         end
      end
   end

   // Snapshot capture, held until next event
   always @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         for (i = 0; i < 12; i = i + 1) begin
            cmd_snap_r[i] <= 32'h0000_0000;
            rsp_snap_r[i] <= 32'h0000_0000;
         end
         snap_valid_r <= 1'b0;
         snap_cnt_r <= 8'h00;
      end else if (any_event) begin
         for (i = 0; i < 12; i = i + 1) begin
            cmd_snap_r[i] <= cmd_live_r[i];
            rsp_snap_r[i] <= rsp_live_r[i];
         end
         snap_valid_r <= 1'b1;
         snap_cnt_r <= snap_cnt_r + 8'h01;
      end
      // Otherwise contents hold
   end

   // Host link order and power state
   always @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         link_state_r <= `LINK_IDLE;
         power_r <= 1'b0;
      end else begin
         case (link_state_r)
            `LINK_IDLE: begin
               power_r <= 1'b0;
               if (host_cmd_valid_in && host_cmd_code_in == `CMD_CONNECT) begin
                  link_state_r <= `LINK_UP;
               end
            end
            `LINK_UP: begin
               if (host_cmd_valid_in && host_cmd_code_in == `CMD_DISCONNECT) begin
                  link_state_r <= `LINK_IDLE;
                  power_r <= 1'b0;
               end else if (alarm_event_in || stop_block) begin
                  power_r <= 1'b0;
               end else if (host_cmd_valid_in && host_cmd_code_in == `CMD_POWER_OFF) begin
                  power_r <= 1'b0;
               end else if (host_cmd_valid_in && host_cmd_code_in == `CMD_POWER_ON) begin
                  power_r <= 1'b1;
               end
            end
            default: begin
               link_state_r <= `LINK_IDLE;
               power_r <= 1'b0;
            end
         endcase
      end
   end

   // Drive outputs
   always @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         motor_power_out <= 1'b0;
         fwd_drive_allow_out <= 1'b0;
         rev_drive_allow_out <= 1'b0;
         order_warning_out <= 1'b0;
      end else begin
         motor_power_out <= power_r & ~stop_block;
         fwd_drive_allow_out <= power_r & ~stop_block & fwd_s2_r;
         rev_drive_allow_out <= power_r & ~stop_block & rev_s2_r;
         order_warning_out <= order_fault;
      end
   end

   // APB slave, zero wait states
   wire setup_phase;
   wire [1:0] region;
   wire [3:0] word_idx;
   wire upper_zero;
   wire snap_hit;
   wire ctrl_hit;
   wire stat_hit;
   reg [31:0] stat_word;
   reg [31:0] rd_nxt;
   reg err_nxt;

   assign setup_phase = psel_in & ~penable_in;
   assign region = paddr_in[7:6];
   assign word_idx = paddr_in[5:2];
   assign upper_zero = (paddr_in[11:8] == 4'h0) && (paddr_in[1:0] == 2'h0);
   assign snap_hit = upper_zero && (region == `REGION_CMD || region == `REGION_RSP) &&
                     (word_idx <= `FRAME_LAST_WORD);
   assign ctrl_hit = upper_zero && region == `REGION_CTL && word_idx == `CTRL_WORD;
   assign stat_hit = upper_zero && region == `REGION_CTL && word_idx == `STAT_WORD;
   assign pready_out = psel_in & penable_in;

   always @* begin
      stat_word = 32'h0000_0000;
      stat_word[`STAT_POWER_BIT] = motor_power_out;
      stat_word[`STAT_CONN_BIT] = link_state_r;
      stat_word[`STAT_STOP_BIT] = stop_s2_r;
      stat_word[`STAT_FWD_BIT] = fwd_s2_r;
      stat_word[`STAT_REV_BIT] = rev_s2_r;
      stat_word[`STAT_VALID_BIT] = snap_valid_r;
      stat_word[`STAT_CNT_MSB:`STAT_CNT_LSB] = snap_cnt_r;
   end

   // Read data and error prepared in the setup cycle
   always @* begin
      rd_nxt = 32'h0000_0000;
      err_nxt = 1'b0;
      if (pwrite_in) begin
         err_nxt = ~ctrl_hit;
      end else if (snap_hit) begin
         if (region == `REGION_CMD) begin
            rd_nxt = cmd_snap_r[word_idx];
         end else begin
            rd_nxt = rsp_snap_r[word_idx];
         end
      end else if (ctrl_hit) begin
         rd_nxt = ctrl_r;
      end else if (stat_hit) begin
         rd_nxt = stat_word;
      end else begin
         err_nxt = 1'b1;
      end
   end

   always @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         prdata_out <= 32'h0000_0000;
         pslverr_out <= 1'b0;
         ctrl_r <= `CTRL_RESET;
      end else begin
         if (setup_phase) begin
            prdata_out <= rd_nxt;
            pslverr_out <= err_nxt;
         end
         if (psel_in && penable_in && pwrite_in && ctrl_hit) begin
            ctrl_r <= {31'h0000_0000, pwdata_in[`CTRL_STOP_EN_BIT]};
         end
      end
   end

endmodule
`default_nettype wire

// ### testbench/afs_checker_assertions.sv
// Port checker for the alarm frame snapshot block
`default_nettype none
module afs_checker (
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic pready_out,
   input wire logic [31:0] prdata_out,
   input wire logic pslverr_out,
   input wire logic host_cmd_valid_in,
   input wire logic [7:0] host_cmd_code_in,
   input wire logic forward_limit_input_in,
   input wire logic reverse_limit_input_in,
   input wire logic motor_power_out,
   input wire logic fwd_drive_allow_out,
   input wire logic rev_drive_allow_out,
   input wire logic order_warning_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);
   a_zero_wait: assert property (psel_in && !penable_in ##1 psel_in && penable_in |-> pready_out)
      else $error("no ready in access");
   a_err_zero: assert property (psel_in && penable_in && !pwrite_in && pslverr_out |-> prdata_out == 32'h0)
      else $error("refused read returned data");
   a_ro_write: assert property (psel_in && penable_in && pwrite_in && paddr_in != 12'h080 |-> pslverr_out)
      else $error("write to read-only accepted");
   a_fwd_blocked: assert property (!forward_limit_input_in [*4] |-> !fwd_drive_allow_out)
      else $error("forward drive while limited");
   a_rev_blocked: assert property (!reverse_limit_input_in [*4] |-> !rev_drive_allow_out)
      else $error("reverse drive while limited");
   a_power_cause: assert property ($rose(motor_power_out) |->
      $past(host_cmd_valid_in, 2) && $past(host_cmd_code_in, 2) == 8'h31)
      else $error("power without command");
   a_order_off: assert property (order_warning_out |-> !motor_power_out)
      else $error("power on out of order");
   a_order_pulse: assert property (order_warning_out |=> !order_warning_out)
      else $error("order warning too long");
endmodule
bind alarm_frame_snapshot afs_checker chk (.*);
`default_nettype wire

// ### testbench/host_model.sv
// Host controller model driving frame bytes and commands
`default_nettype none
module host_model (
   input wire logic sys_clk_in,
   output logic cmd_byte_we_in,
   output logic rsp_byte_we_in,
   output logic host_cmd_valid_in,
   output logic [5:0] cmd_byte_idx_in,
   output logic [5:0] rsp_byte_idx_in,
   output logic [7:0] cmd_byte_in,
   output logic [7:0] rsp_byte_in,
   output logic [7:0] host_cmd_code_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {cmd_byte_we_in, rsp_byte_we_in, host_cmd_valid_in, cmd_byte_idx_in, rsp_byte_idx_in} = 15'h0;
   initial {cmd_byte_in, rsp_byte_in, host_cmd_code_in} = 24'h0;
   // Both frames, byte i is seed plus i, response inverted
   task automatic frame(input logic [7:0] seed);
      for (int i = 0; i < 48; i++) begin
         @(posedge sys_clk_in);
         {cmd_byte_we_in, rsp_byte_we_in} <= 2'h3;
         {cmd_byte_idx_in, rsp_byte_idx_in} <= {2{6'(i)}};
         cmd_byte_in <= seed + 8'(i);
         rsp_byte_in <= ~(seed + 8'(i));
      end
      @(posedge sys_clk_in);
      {cmd_byte_we_in, rsp_byte_we_in} <= 2'h0;
      {cmd_byte_in, rsp_byte_in} <= {~cmd_byte_in, ~rsp_byte_in};
   endtask
   // One command pulse, code scrambled after
   task automatic cmd(input logic [7:0] code);
      @(posedge sys_clk_in);
      host_cmd_valid_in <= 1'b1;
      host_cmd_code_in <= code;
      @(posedge sys_clk_in);
      host_cmd_valid_in <= 1'b0;
      host_cmd_code_in <= ~code;
   endtask
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the alarm frame snapshot block
`include "alarm_frame_snapshot_map.vh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_in = 1'b0, rst_b_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
   logic pready_out, pslverr_out, motor_power_out, fwd_drive_allow_out, rev_drive_allow_out, order_warning_out, err;
   logic cmd_byte_we_in, rsp_byte_we_in, host_cmd_valid_in, alarm_event_in, data_warning_in, command_warning_in;
   logic [5:0] cmd_byte_idx_in, rsp_byte_idx_in;
   logic [7:0] cmd_byte_in, rsp_byte_in, host_cmd_code_in;
   logic [2:0] ev = 3'h0;
   logic forced_stop_input_in = 1'b1, forward_limit_input_in = 1'b1, reverse_limit_input_in = 1'b1;
   int failures = 0, check_count = 0;
   assign {alarm_event_in, data_warning_in, command_warning_in} = ev;
   always #12.5 sys_clk_in = ~sys_clk_in;
   alarm_frame_snapshot uut (.*);
   host_model host (.*);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'h2, wr, a, d};
      @(posedge sys_clk_in);
      penable_in <= 1'b1;
      do @(posedge sys_clk_in); while (pready_out !== 1'b1);
      rd = prdata_out;
      err = pslverr_out;
      {psel_in, penable_in} <= 2'h0;
   endtask
   task automatic fire(input logic [2:0] v);
      @(posedge sys_clk_in);
      ev <= v;
      @(posedge sys_clk_in);
      ev <= 3'h0;
   endtask
   function automatic logic [31:0] word(input logic [7:0] s, input int w);
      logic [7:0] b;
      b = s + 8'(4 * w);
      return {b + 8'h3, b + 8'h2, b + 8'h1, b};
   endfunction
   task automatic wait_lvl;
      repeat (5) @(posedge sys_clk_in);
   endtask
   task automatic t_capture;
      for (int k = 0; k < 3; k++) begin
         host.frame(8'(64 * k));
         fire(3'h4 >> k);
         for (int w = 0; w < 12; w++) begin
            apb(1'b0, 12'(4 * w), 32'h0);
            check(rd, word(8'(64 * k), w));
            apb(1'b0, 12'(64 + 4 * w), 32'h0);
            check(rd, ~word(8'(64 * k), w));
         end
         apb(1'b0, 12'h084, 32'h0);
         check(rd[15:8], 32'(k + 1));
      end
      host.frame(8'h33);
      apb(1'b0, 12'h02C, 32'h0);
      check(rd, word(8'h80, 11));
      apb(1'b1, 12'h000, 32'h0);
      check(err, 1'b1);
      apb(1'b0, 12'h100, 32'h0);
      check(err, 1'b1);
   endtask
   task automatic t_power;
      apb(1'b0, 12'h080, 32'h0);
      check(rd, 32'h1);
      host.cmd(`CMD_POWER_ON);
      #1;
      check(order_warning_out, 1'b1);
      host.cmd(`CMD_CONNECT);
      host.cmd(`CMD_POWER_ON);
      wait_lvl;
      check({motor_power_out, fwd_drive_allow_out}, 2'h3);
      forward_limit_input_in <= 1'b0;
      wait_lvl;
      check({fwd_drive_allow_out, rev_drive_allow_out}, 2'h1);
      forced_stop_input_in <= 1'b0;
      wait_lvl;
      check(motor_power_out, 1'b0);
      forced_stop_input_in <= 1'b1;
      wait_lvl;
      check(motor_power_out, 1'b0);
      apb(1'b1, 12'h080, 32'h0);
      forced_stop_input_in <= 1'b0;
      host.cmd(`CMD_POWER_ON);
      wait_lvl;
      check(motor_power_out, 1'b1);
      reverse_limit_input_in <= 1'b0;
      wait_lvl;
      check({motor_power_out, fwd_drive_allow_out, rev_drive_allow_out}, 3'h4);
      host.cmd(`CMD_POWER_OFF);
      wait_lvl;
      check(motor_power_out, 1'b0);
      host.cmd(`CMD_DISCONNECT);
      host.cmd(`CMD_POWER_ON);
      #1;
      check(order_warning_out, 1'b1);
      wait_lvl;
      check(motor_power_out, 1'b0);
   endtask
   task automatic end_sim;
      if (failures == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #200us;
      failures++;
      end_sim;
   end
   initial begin
      repeat (16) @(posedge sys_clk_in);
      rst_b_in <= 1'b1;
      t_capture;
      t_power;
      end_sim;
   end
endmodule
`default_nettype wire
